//--- common/bag_pkg.sv
// Overview of operation
// R1 - Secure on at level 1: boot only in root services or secure flash 0x0C000000-0x0C1FFFFF.
// R2 - Secure on, level 1, address outside that region: fixed vector 0x0FF80000 is used.
// R3 - Secure off at level 2: boot only in flash 0x08000000-0x081FFFFF.
// R4 - Secure off, level 2, address outside that window: vector 0x08000000 is used instead.
// R5 - Forcing applies only at level 0.5 or above; below it the address passes unchanged.
// R6 - With the security extension on, the secure boot address option gives the boot location.
// R7 - With the single-boot-entry lock set, only the secure boot address option is used.
// R8 - Secure off at level 1: the requested address passes through unchecked.
`default_nettype none
package bag_pkg;
    // ------------------------------------------------------------
    // Protection level encodings
    // ------------------------------------------------------------
    localparam logic [1:0] BAG_LVL_0    = 2'h0;
    localparam logic [1:0] BAG_LVL_0P5  = 2'h1;
    localparam logic [1:0] BAG_LVL_1    = 2'h2;
    localparam logic [1:0] BAG_LVL_2    = 2'h3;
    // ------------------------------------------------------------
    // Address windows and forced vectors
    // ------------------------------------------------------------
    localparam logic [31:0] BAG_SEC_FLASH_LO  = 32'h0C00_0000;
    localparam logic [31:0] BAG_SEC_FLASH_HI  = 32'h0C1F_FFFF;
    localparam logic [31:0] BAG_ROOT_SVC_VECTOR = 32'h0FF8_0000;
    localparam logic [31:0] BAG_NS_FLASH_LO   = 32'h0800_0000;
    localparam logic [31:0] BAG_NS_FLASH_HI   = 32'h081F_FFFF;
    localparam logic [31:0] BAG_NS_FORCED     = 32'h0800_0000;
    localparam logic [31:0] BAG_RESET_ADDR    = 32'h0000_0000;
    // Root security services window size; a plain default, widen to the real region
    localparam logic [31:0] BAG_ROOT_SVC_SPAN = 32'h0000_FFFF;
endpackage
`default_nettype wire

//--- hdl/bag_range_check.sv
`default_nettype none
module bag_range_check
(
    input  wire logic [31:0] addr,
    input  wire logic [31:0] lo,
    input  wire logic [31:0] hi,
    output logic             in_window
);
    // Inclusive window compare
    assign in_window = (addr >= lo) && (addr <= hi);
endmodule
`default_nettype wire

//--- hdl/bag_boot_address_guard.sv
`default_nettype none
module bag_boot_address_guard
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [1:0]  readout_protection_level,
    input  wire logic        security_extension_enable,
    input  wire logic        boot_lock,
    input  wire logic [31:0] requested_boot_address,
    input  wire logic [31:0] secure_boot_address_option,
    output logic [31:0]      effective_boot_address,
    output logic             boot_address_forced,
    output logic             boot_address_valid
);
    import bag_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Option bytes and pins come from outside this clock, two stages each
    // Words are synced bit by bit: they must be static, a change may show one mixed value
    logic [1:0]  lvl_s1;
    logic [1:0]  lvl;
    logic        sec_s1;
    logic        sec;
    logic        lock_s1;
    logic        lock;
    logic [31:0] req_s1;
    logic [31:0] req;
    logic [31:0] sba_s1;
    logic [31:0] sba;

    // Protection level; resets to the open level so nothing is forced while filling
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lvl_s1 <= BAG_LVL_0;
            lvl    <= BAG_LVL_0;
        end
        else
        begin
            lvl_s1 <= readout_protection_level;
            lvl    <= lvl_s1;
        end
    end

    // Security extension enable
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sec_s1 <= 1'b0;
            sec    <= 1'b0;
        end
        else
        begin
            sec_s1 <= security_extension_enable;
            sec    <= sec_s1;
        end
    end

    // Single-boot-entry lock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_s1 <= 1'b0;
            lock    <= 1'b0;
        end
        else
        begin
            lock_s1 <= boot_lock;
            lock    <= lock_s1;
        end
    end

    // Requested boot address
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_s1 <= BAG_RESET_ADDR;
            req    <= BAG_RESET_ADDR;
        end
        else
        begin
            req_s1 <= requested_boot_address;
            req    <= req_s1;
        end
    end

    // Secure boot address option
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sba_s1 <= BAG_RESET_ADDR;
            sba    <= BAG_RESET_ADDR;
        end
        else
        begin
            sba_s1 <= secure_boot_address_option;
            sba    <= sba_s1;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Secure mode or the lock take the secure option; lock ignores the request
    wire         use_secure = sec | lock;                       // [R6] [R7]
    wire [31:0]  candidate  = use_secure ? sba : req;           // [R6] [R7]

    // ------------------------------------------------------------
    // Window checks
    // ------------------------------------------------------------
    // Top of the root services window, cut to the address width on purpose
    localparam logic [31:0] ROOT_SVC_HI = 32'(BAG_ROOT_SVC_VECTOR + BAG_ROOT_SVC_SPAN);

    logic in_sec_flash;
    logic in_ns_flash;
    logic in_root_svc;

    bag_range_check u_sec_flash
    (
        .addr      (candidate),
        .lo        (BAG_SEC_FLASH_LO),
        .hi        (BAG_SEC_FLASH_HI),
        .in_window (in_sec_flash)
    );

    bag_range_check u_ns_flash
    (
        .addr      (candidate),
        .lo        (BAG_NS_FLASH_LO),
        .hi        (BAG_NS_FLASH_HI),
        .in_window (in_ns_flash)
    );

    bag_range_check u_root_svc
    (
        .addr      (candidate),
        .lo        (BAG_ROOT_SVC_VECTOR),
        .hi        (ROOT_SVC_HI),
        .in_window (in_root_svc)
    );

    // ------------------------------------------------------------
    // Forcing decision
    // ------------------------------------------------------------
    // Decision per combination, where secure source means extension on or lock set:
    //   level 0               : candidate passes untouched
    //   secure, level 0.5 to 2: secure flash or root services window, else root vector
    //   plain, level 0.5 or 1 : candidate passes untouched
    //   plain, level 2        : plain flash window, else flash base
    // Forcing only from level 0.5 up; level 0 passes untouched
    wire protected_lvl = (lvl != BAG_LVL_0);                    // [R5]
    // Level 2 in secure mode is treated like level 1: stricter never hurts
    wire sec_strict    = use_secure && protected_lvl;
    wire sec_bad       = sec_strict && !(in_sec_flash || in_root_svc); // [R1]
    wire ns_strict     = !use_secure && (lvl == BAG_LVL_2);
    wire ns_bad        = ns_strict && !in_ns_flash;             // [R3]
    // Non-secure level 1 (and 0.5, unused there) pass straight through [R8]

    // Substitution is a plain mux, so a bad option costs no extra cycle
    wire [31:0] next_effective = sec_bad ? BAG_ROOT_SVC_VECTOR : // [R2]
                                 ns_bad  ? BAG_NS_FORCED       : // [R4]
                                 candidate;                      // [R8]
    // The flag lets start-up code tell a forced vector from a chosen one
    wire        next_forced    = sec_bad | ns_bad;

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Fill marker, one bit per synchroniser stage since reset release
    logic [1:0] fill;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fill <= 2'h0;
        end
        else
        begin
            fill <= {fill[0], 1'b1};
        end
    end

    // Effective address register; the port comes straight from here
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            effective_boot_address <= BAG_RESET_ADDR;
        end
        else
        begin
            effective_boot_address <= next_effective;       // [R2] [R4]
        end
    end

    // Substitution flag register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_address_forced <= 1'b0;
        end
        else
        begin
            boot_address_forced <= next_forced;
        end
    end

    // Valid rises on the third edge after release, once real inputs reach the result
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_address_valid <= 1'b0;
        end
        else
        begin
            boot_address_valid <= fill[1];
        end
    end
endmodule
`default_nettype wire

//--- tb/bag_checker.sv
`default_nettype none
module bag_checker
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [1:0]  readout_protection_level,
    input wire logic        security_extension_enable,
    input wire logic        boot_lock,
    input wire logic [31:0] requested_boot_address,
    input wire logic [31:0] secure_boot_address_option,
    input wire logic [31:0] effective_boot_address,
    input wire logic        boot_address_forced,
    input wire logic        boot_address_valid
);
    // Lock also selects the secure option, so the secure checks follow it
    wire logic        sp  = security_extension_enable | boot_lock;
    wire logic [1:0]  lv  = readout_protection_level;
    wire logic [31:0] src = sp ? secure_boot_address_option : requested_boot_address;
    wire logic        s_ok = (src >= 32'h0C00_0000 && src <= 32'h0C1F_FFFF)
                          || (src >= 32'h0FF8_0000 && src <= 32'h0FF8_FFFF);
    wire logic        n_ok = src >= 32'h0800_0000 && src <= 32'h081F_FFFF;
    wire logic        sec_chk = sp && lv != 2'h0;
    wire logic        ns_chk  = !sp && lv == 2'h3;
    wire logic [31:0] ea  = effective_boot_address;
    wire logic        v   = boot_address_valid;
    wire logic        f   = boot_address_forced;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Result compares against inputs three edges back
    sequence s_held;
        v ##1 v;
    endsequence
    a_valid_stays: assert property (v |-> s_held) else $error("valid dropped");
    a_low_pass: assert property (v && $past(lv == 2'h0, 3)
        |-> ea == $past(src, 3) && !f) else $error("level 0 altered");
    a_sec_keep: assert property (v && $past(sec_chk && s_ok, 3)
        |-> ea == $past(src, 3) && !f) else $error("secure kept bad");
    a_sec_force: assert property (v && $past(sec_chk && !s_ok, 3)
        |-> ea == 32'h0FF8_0000 && f) else $error("secure force bad");
    a_ns_keep: assert property (v && $past(ns_chk && n_ok, 3)
        |-> ea == $past(src, 3) && !f) else $error("flash kept bad");
    a_ns_force: assert property (v && $past(ns_chk && !n_ok, 3)
        |-> ea == 32'h0800_0000 && f) else $error("flash force bad");
    a_l1_pass: assert property (v && $past(!sp && lv inside {2'h1, 2'h2}, 3)
        |-> ea == $past(src, 3) && !f) else $error("pass altered");
    a_sec_source: assert property (v && $past(sp && lv == 2'h0, 3)
        |-> ea == $past(secure_boot_address_option, 3)) else $error("secure source bad");
endmodule
bind bag_boot_address_guard bag_checker u_bag_checker (.clk, .arst_n, .readout_protection_level,
    .security_extension_enable, .boot_lock, .requested_boot_address, .secure_boot_address_option,
    .effective_boot_address, .boot_address_forced, .boot_address_valid);
`default_nettype wire

//--- tb/bag_boot_address_guard_test.sv
`default_nettype none
module bag_boot_address_guard_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, arst_n, sec, lock, forced, valid;
    logic [1:0]  lvl;
    logic [31:0] req, opt, ea;
    int          mismatches, n_compared;
    bag_boot_address_guard u_bag_boot_address_guard (.clk(clk), .arst_n(arst_n),
        .readout_protection_level(lvl), .security_extension_enable(sec), .boot_lock(lock),
        .requested_boot_address(req), .secure_boot_address_option(opt),
        .effective_boot_address(ea), .boot_address_forced(forced), .boot_address_valid(valid));
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Result lags three edges, so four are waited before looking
    task automatic apply(input logic [1:0] l, input logic s, k, input logic [31:0] r, o, e,
                         input logic ef);
        @(posedge clk) #1;
        lvl = l;
        sec = s;
        lock = k;
        req = r;
        opt = o;
        repeat (4) @(posedge clk);
        #1 check({forced, ea}, {ef, e});
    endtask
    task automatic t_sec;
        apply(2'h2, 1, 0, 0, 32'h0C1F_FFFF, 32'h0C1F_FFFF, 0);
        apply(2'h2, 1, 0, 0, 32'h0C20_0000, 32'h0FF8_0000, 1);
        apply(2'h1, 1, 0, 0, 32'h0BFF_FFFF, 32'h0FF8_0000, 1);
        apply(2'h2, 1, 0, 0, 32'h0FF8_FFFF, 32'h0FF8_FFFF, 0);
        apply(2'h3, 1, 0, 0, 32'h0800_0000, 32'h0FF8_0000, 1);
        apply(2'h0, 1, 0, 32'h0800_0000, 32'h2000_0000, 32'h2000_0000, 0);
    endtask
    task automatic t_flash;
        apply(2'h3, 0, 0, 32'h081F_FFFF, 0, 32'h081F_FFFF, 0);
        apply(2'h3, 0, 0, 32'h0820_0000, 0, 32'h0800_0000, 1);
        apply(2'h3, 0, 0, 32'h07FF_FFFF, 0, 32'h0800_0000, 1);
        apply(2'h2, 0, 0, 32'h2000_0000, 0, 32'h2000_0000, 0);
        apply(2'h0, 0, 0, 32'h2000_0000, 0, 32'h2000_0000, 0);
    endtask
    task automatic t_lock;
        apply(2'h0, 0, 1, 32'h0800_0000, 32'h0C00_0000, 32'h0C00_0000, 0);
        apply(2'h3, 0, 1, 32'h0800_0000, 32'h0C00_0010, 32'h0C00_0010, 0);
    endtask
    task automatic t_reset;
        @(posedge clk) #1 arst_n = 1'b0;
        #1 check({forced, ea}, 33'h0);
        @(posedge clk) #1 arst_n = 1'b1;
        @(posedge clk) #1 check(valid, 1'b0);
        repeat (3) @(posedge clk);
        #1 check(valid, 1'b1);
        check({forced, ea}, {1'b0, 32'h0C00_0010});
    endtask
    task automatic finish_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence; inputs stay stable through reset
    initial
    begin
        {arst_n, sec, lock, lvl, req, opt} = '0;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        t_sec;
        t_flash;
        t_lock;
        t_reset;
        finish_test;
    end
    // Watchdog well past the expected run length
    initial
    begin
        #5000;
        mismatches++;
        finish_test;
    end
endmodule
`default_nettype wire
